// ==== src/capture_pkg.sv ====
`default_nettype none

package capture_pkg;

   // =====================================================================
   // widths
   // =====================================================================
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 2;
   localparam int LANE_W = 16;
   localparam int IRQ_W = 2;

   // =====================================================================
   // register byte offsets
   // =====================================================================
   localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h54;
   localparam logic [ADDR_W-1:0] CH2_RISE_OFF = 8'h68;
   localparam logic [ADDR_W-1:0] CH2_FALL_OFF = 8'h6C;
   localparam logic [ADDR_W-1:0] CH3_RISE_OFF = 8'h70;
   localparam logic [ADDR_W-1:0] CH3_FALL_OFF = 8'h74;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 8'h80;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h84;

   // =====================================================================
   // field positions inside one channel lane of the control register
   // =====================================================================
   localparam int INV_BIT = 0;
   localparam int RISE_IE_BIT = 1;
   localparam int FALL_IE_BIT = 2;
   localparam int EN_BIT = 3;
   localparam int CAPIF_BIT = 4;
   localparam int RISE_FLAG_BIT = 6;
   localparam int FALL_FLAG_BIT = 7;

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [LANE_W-1:0] LANE_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] LATCH_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // =====================================================================
   // carriers
   // =====================================================================
   typedef struct packed {
      logic en;
      logic fall_ie;
      logic rise_ie;
      logic invert;
   } cap_cfg_t;

   localparam cap_cfg_t CFG_RESET = '{en: 1'b0, fall_ie: 1'b0, rise_ie: 1'b0, invert: 1'b0};

   typedef struct packed {
      logic rise;
      logic fall;
      logic irq;
   } cap_evt_t;

   // a write clears a flag when the written bit equals the clearing value
   function automatic logic flag_clear(input logic wr, input logic wbit, input logic clr_val);
      return wr & (wbit == clr_val);
   endfunction : flag_clear

endpackage : capture_pkg

`default_nettype wire

// ==== src/pin_sync.sv ====
`default_nettype none

module pin_sync
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pin and synchronised level
   input wire logic pin_async,
   output logic pin_level
);

   logic meta;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= 1'b0;
         pin_level <= 1'b0;
      end
      else
      begin
         meta <= pin_async;
         pin_level <= meta;
      end
   end

endmodule : pin_sync

`default_nettype wire

// ==== src/capture_channel.sv ====
`default_nettype none

module capture_channel
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // synchronised pin and configuration
   input wire logic pin_level,
   input wire capture_pkg::cap_cfg_t cfg,
   // counter of the pwm group
   input wire logic [capture_pkg::CNT_W-1:0] count,
   // captured values and events
   output logic [capture_pkg::CNT_W-1:0] rise_val,
   output logic [capture_pkg::CNT_W-1:0] fall_val,
   output capture_pkg::cap_evt_t evt
);

   // =====================================================================
   // edge detection
   // =====================================================================
   logic prev;
   wire logic lvl;
   wire logic rise_edge;
   wire logic fall_edge;
   wire logic cap_rise;
   wire logic cap_fall;

   assign lvl = pin_level ^ cfg.invert;
   assign rise_edge = lvl & ~prev;
   assign fall_edge = ~lvl & prev;
   assign cap_rise = cfg.en & rise_edge;
   assign cap_fall = cfg.en & fall_edge;

   assign evt.rise = cap_rise;
   assign evt.fall = cap_fall;
   assign evt.irq = (cap_rise & cfg.rise_ie) | (cap_fall & cfg.fall_ie);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev <= 1'b0;
      else
         prev <= lvl;
   end

   // =====================================================================
   // counter latches
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rise_val <= capture_pkg::LATCH_RESET;
         fall_val <= capture_pkg::LATCH_RESET;
      end
      else
      begin
         if (cap_rise)
            rise_val <= count;
         if (cap_fall)
            fall_val <= count;
      end
   end

endmodule : capture_channel

`default_nettype wire

// ==== src/pwm_capture_ctrl_ch2_ch3.sv ====
// Summary of operation
// - With channel 3 enabled, each edge stores the counter in the rising or falling latch.
// - With channel 3 disabled its latches hold and its capture interrupt stays quiet.
// - Bit 18 set lets a channel 3 falling edge raise the capture interrupt.
// - Bit 17 set lets a channel 3 rising edge raise the capture interrupt.
// - Bit 16 set inverts the channel 3 input before edge detection.
// - A channel 2 falling edge stores the counter in the falling latch and sets bit 7.
// - A channel 2 rising edge stores the counter in the rising latch and sets bit 6.
// - In the medium-density variant a write of 0 clears a latched-indicator bit.
// - In the low-density variant an indicator clears on a write equal to the clear-mode bit.
// - With the channel 2 rising interrupt enable set, a rising edge sets bit 4.
// - With the channel 2 falling interrupt enable set, a falling edge sets bit 4.
// - Writing 1 to the capture interrupt flag clears it; writing 0 leaves it.
// - Bits 15 to 8 and bit 5 of the control register do nothing and read zero.
// - Bit 3 holds the channel 2 capture enable.
// - The channel 2 enable gates latch updates and the channel interrupt like channel 3's.
// - Each latch register holds the captured value in its low 16 bits, upper bits zero.
//
// Added by the designer: the address map and the APB slave port.

`default_nettype none

module pwm_capture_ctrl_ch2_ch3
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [capture_pkg::ADDR_W-1:0] paddr,
   input wire logic [capture_pkg::DATA_W-1:0] pwdata,
   output logic [capture_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // capture pins
   input wire logic cap_pin_ch2,
   input wire logic cap_pin_ch3,
   // pwm group
   input wire logic [capture_pkg::CNT_W-1:0] pwm_count,
   input wire logic low_density,
   input wire logic flag_clear_polarity,
   // interrupt
   output logic irq
);

   // =====================================================================
   // state
   // =====================================================================
   capture_pkg::cap_cfg_t [capture_pkg::NUM_CH-1:0] cfg;
   logic [capture_pkg::NUM_CH-1:0] capif;
   logic [capture_pkg::NUM_CH-1:0] rise_flag;
   logic [capture_pkg::NUM_CH-1:0] fall_flag;
   logic [capture_pkg::IRQ_W-1:0] irq_status;
   logic [capture_pkg::IRQ_W-1:0] irq_mask;

   capture_pkg::cap_cfg_t [capture_pkg::NUM_CH-1:0] next_cfg;
   logic [capture_pkg::NUM_CH-1:0] next_capif;
   logic [capture_pkg::NUM_CH-1:0] next_rise_flag;
   logic [capture_pkg::NUM_CH-1:0] next_fall_flag;
   logic [capture_pkg::IRQ_W-1:0] next_irq_status;
   logic [capture_pkg::IRQ_W-1:0] next_irq_mask;

   capture_pkg::cap_evt_t [capture_pkg::NUM_CH-1:0] evt;
   logic [capture_pkg::NUM_CH-1:0][capture_pkg::CNT_W-1:0] rise_val;
   logic [capture_pkg::NUM_CH-1:0][capture_pkg::CNT_W-1:0] fall_val;
   logic [capture_pkg::NUM_CH-1:0] pin_async;
   logic [capture_pkg::NUM_CH-1:0] pin_level;

   assign pin_async = {cap_pin_ch3, cap_pin_ch2};

   // =====================================================================
   // lane assembly of the control word
   // =====================================================================
   function automatic logic [capture_pkg::LANE_W-1:0] lane_word(
      input capture_pkg::cap_cfg_t c,
      input logic ifl,
      input logic rfl,
      input logic ffl
   );
      logic [capture_pkg::LANE_W-1:0] w;
      w = capture_pkg::LANE_ZERO;
      w[capture_pkg::INV_BIT] = c.invert;
      w[capture_pkg::RISE_IE_BIT] = c.rise_ie;
      w[capture_pkg::FALL_IE_BIT] = c.fall_ie;
      w[capture_pkg::EN_BIT] = c.en;
      w[capture_pkg::CAPIF_BIT] = ifl;
      w[capture_pkg::RISE_FLAG_BIT] = rfl;
      w[capture_pkg::FALL_FLAG_BIT] = ffl;
      return w;
   endfunction : lane_word

   function automatic logic [capture_pkg::DATA_W-1:0] latch_word(
      input logic [capture_pkg::CNT_W-1:0] v
   );
      logic [capture_pkg::DATA_W-1:0] w;
      w = capture_pkg::WORD_ZERO;
      w[capture_pkg::CNT_W-1:0] = v;
      return w;
   endfunction : latch_word

   function automatic logic [capture_pkg::DATA_W-1:0] irq_word(
      input logic [capture_pkg::IRQ_W-1:0] v
   );
      logic [capture_pkg::DATA_W-1:0] w;
      w = capture_pkg::WORD_ZERO;
      w[capture_pkg::IRQ_W-1:0] = v;
      return w;
   endfunction : irq_word

   // =====================================================================
   // channels
   // =====================================================================
   // one synchroniser and one edge and latch unit per channel
   genvar gi;
   generate
      for (gi = 0; gi < capture_pkg::NUM_CH; gi++)
      begin : g_ch
         pin_sync u_sync
         (
            .pclk(pclk),
            .presetn(presetn),
            .pin_async(pin_async[gi]),
            .pin_level(pin_level[gi])
         );

         capture_channel u_chan
         (
            .pclk(pclk),
            .presetn(presetn),
            .pin_level(pin_level[gi]),
            .cfg(cfg[gi]),
            .count(pwm_count),
            .rise_val(rise_val[gi]),
            .fall_val(fall_val[gi]),
            .evt(evt[gi])
         );
      end
   endgenerate

   // =====================================================================
   // apb decode
   // =====================================================================
   wire logic setup_phase;
   wire logic access_phase;
   wire logic wr_access;
   wire logic rd_access;
   wire logic sel_ctrl;
   wire logic sel_ch2_rise;
   wire logic sel_ch2_fall;
   wire logic sel_ch3_rise;
   wire logic sel_ch3_fall;
   wire logic sel_status;
   wire logic sel_mask;
   wire logic addr_hit;
   wire logic wr_ctrl;
   wire logic wr_mask;
   wire logic rd_status;
   wire logic clr_val;
   wire logic [capture_pkg::DATA_W-1:0] ctrl_word;
   wire logic [capture_pkg::DATA_W-1:0] read_value;

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access = access_phase & pwrite;
   assign rd_access = access_phase & ~pwrite;

   assign sel_ctrl = (paddr == capture_pkg::CTRL_OFF);
   assign sel_ch2_rise = (paddr == capture_pkg::CH2_RISE_OFF);
   assign sel_ch2_fall = (paddr == capture_pkg::CH2_FALL_OFF);
   assign sel_ch3_rise = (paddr == capture_pkg::CH3_RISE_OFF);
   assign sel_ch3_fall = (paddr == capture_pkg::CH3_FALL_OFF);
   assign sel_status = (paddr == capture_pkg::IRQ_STATUS_OFF);
   assign sel_mask = (paddr == capture_pkg::IRQ_MASK_OFF);
   assign addr_hit = sel_ctrl | sel_ch2_rise | sel_ch2_fall | sel_ch3_rise | sel_ch3_fall
                     | sel_status | sel_mask;

   assign wr_ctrl = wr_access & sel_ctrl;
   assign wr_mask = wr_access & sel_mask;
   assign rd_status = rd_access & sel_status;

   // one wait-free access phase; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access_phase & ~addr_hit;

   assign ctrl_word = {lane_word(cfg[1], capif[1], rise_flag[1], fall_flag[1]),
                       lane_word(cfg[0], capif[0], rise_flag[0], fall_flag[0])};

   assign read_value = sel_ctrl ? ctrl_word :
                       sel_ch2_rise ? latch_word(rise_val[0]) :
                       sel_ch2_fall ? latch_word(fall_val[0]) :
                       sel_ch3_rise ? latch_word(rise_val[1]) :
                       sel_ch3_fall ? latch_word(fall_val[1]) :
                       sel_status ? irq_word(irq_status) :
                       sel_mask ? irq_word(irq_mask) :
                       capture_pkg::WORD_ZERO;

   // medium density clears on 0, low density on the clear-mode value
   assign clr_val = low_density ? flag_clear_polarity : 1'b0;

   // =====================================================================
   // next values of control and flags
   // =====================================================================
   generate
      for (gi = 0; gi < capture_pkg::NUM_CH; gi++)
      begin : g_next
         wire logic [capture_pkg::LANE_W-1:0] wl;
         assign wl = pwdata[capture_pkg::LANE_W*gi +: capture_pkg::LANE_W];

         assign next_cfg[gi].invert = wr_ctrl ? wl[capture_pkg::INV_BIT] : cfg[gi].invert;
         assign next_cfg[gi].rise_ie = wr_ctrl ? wl[capture_pkg::RISE_IE_BIT] : cfg[gi].rise_ie;
         assign next_cfg[gi].fall_ie = wr_ctrl ? wl[capture_pkg::FALL_IE_BIT] : cfg[gi].fall_ie;
         assign next_cfg[gi].en = wr_ctrl ? wl[capture_pkg::EN_BIT] : cfg[gi].en;

         wire logic clr_rise;
         wire logic clr_fall;
         wire logic clr_irq;

         // latched flags clear on the variant's value, the interrupt flag on a written 1
         assign clr_rise = capture_pkg::flag_clear(wr_ctrl, wl[capture_pkg::RISE_FLAG_BIT],
            clr_val);
         assign clr_fall = capture_pkg::flag_clear(wr_ctrl, wl[capture_pkg::FALL_FLAG_BIT],
            clr_val);
         assign clr_irq = capture_pkg::flag_clear(wr_ctrl, wl[capture_pkg::CAPIF_BIT],
            1'b1);

         // hardware set wins over a clear in the same cycle
         assign next_rise_flag[gi] = evt[gi].rise | (rise_flag[gi] & ~clr_rise);
         assign next_fall_flag[gi] = evt[gi].fall | (fall_flag[gi] & ~clr_fall);
         assign next_capif[gi] = evt[gi].irq | (capif[gi] & ~clr_irq);
      end
   endgenerate

   // =====================================================================
   // interrupt status and mask
   // =====================================================================
   // only bits already shown in the read data are cleared, so an event
   // landing between setup and access is kept
   wire logic [capture_pkg::IRQ_W-1:0] status_clear;
   wire logic [capture_pkg::IRQ_W-1:0] status_set;

   assign status_set = {evt[1].irq, evt[0].irq};
   assign status_clear = rd_status ? prdata[capture_pkg::IRQ_W-1:0] : capture_pkg::IRQ_RESET;
   assign next_irq_status = status_set | (irq_status & ~status_clear);
   assign next_irq_mask = wr_mask ? pwdata[capture_pkg::IRQ_W-1:0] : irq_mask;
   assign irq = |(irq_status & irq_mask);

   // =====================================================================
   // registers
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= {capture_pkg::NUM_CH{capture_pkg::CFG_RESET}};
         capif <= '0;
         rise_flag <= '0;
         fall_flag <= '0;
      end
      else
      begin
         cfg <= next_cfg;
         capif <= next_capif;
         rise_flag <= next_rise_flag;
         fall_flag <= next_fall_flag;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= capture_pkg::IRQ_RESET;
         irq_mask <= capture_pkg::IRQ_RESET;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
      end
   end

   // =====================================================================
   // read data
   // =====================================================================
   // read data is taken in the setup cycle and stands through the access phase
   wire logic rd_setup;

   assign rd_setup = setup_phase & ~pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= capture_pkg::WORD_ZERO;
      else if (rd_setup)
         prdata <= read_value;
   end

endmodule : pwm_capture_ctrl_ch2_ch3

`default_nettype wire

// ==== tb/capture_properties.sv ====
`default_nettype none

module capture_properties
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [capture_pkg::ADDR_W-1:0] paddr,
   input wire logic [capture_pkg::DATA_W-1:0] pwdata,
   input wire logic [capture_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins, group and interrupt
   input wire logic cap_pin_ch2,
   input wire logic cap_pin_ch3,
   input wire logic [capture_pkg::CNT_W-1:0] pwm_count,
   input wire logic low_density,
   input wire logic flag_clear_polarity,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // helpers
   // =====================================================================
   logic pin2_q;
   logic pin3_q;
   wire logic acc = psel & penable;
   wire logic rd_acc = acc & !pwrite;
   wire logic wr_any = acc & pwrite;
   wire logic latch_adr = (paddr >= capture_pkg::CH2_RISE_OFF) &
      (paddr <= capture_pkg::CH3_FALL_OFF) & (paddr[1:0] == 2'h0);
   wire logic mapped = latch_adr | (paddr == capture_pkg::CTRL_OFF) |
      (paddr == capture_pkg::IRQ_STATUS_OFF) | (paddr == capture_pkg::IRQ_MASK_OFF);
   wire logic rd_stat = psel & !pwrite & (paddr == capture_pkg::IRQ_STATUS_OFF);
   wire logic chg = (cap_pin_ch2 ^ pin2_q) | (cap_pin_ch3 ^ pin3_q);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin2_q <= 1'b0;
         pin3_q <= 1'b0;
      end
      else
      begin
         pin2_q <= cap_pin_ch2;
         pin3_q <= cap_pin_ch3;
      end
   end
   // =====================================================================
   // properties
   // =====================================================================
   property p_err_unmapped;
      acc && !mapped |-> pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("no error on unmapped access");
   property p_err_mapped;
      !(acc && !mapped) |-> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped)
      else $error("error outside unmapped access");
   property p_unmapped_zero;
      rd_acc && !mapped |-> prdata == capture_pkg::WORD_ZERO;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   property p_latch_upper;
      rd_acc && latch_adr |-> prdata[31:16] == 16'h0000;
   endproperty
   a_latch_upper: assert property (p_latch_upper)
      else $error("latch upper half not zero");
   property p_ctrl_reserved;
      rd_acc && paddr == capture_pkg::CTRL_OFF |-> (prdata & 32'hFF20_FF20) == 32'h0000_0000;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved)
      else $error("reserved control bit set");
   property p_rdata_hold;
      !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved outside read setup");
   property p_irq_rise;
      $rose(irq) |-> $past(chg, 3) || $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3);
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt rose without a cause");
   property p_irq_fall;
      $fell(irq) |-> $past(rd_stat) || $past(wr_any);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt fell without a clear");
   c_ctrl_wr: cover property (wr_any && paddr == capture_pkg::CTRL_OFF);
   c_irq: cover property ($rose(irq));
   c_unmapped: cover property (acc && !mapped);
endmodule : capture_properties

`default_nettype wire

// ==== tb/capture_partner.sv ====
`default_nettype none

module capture_partner
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench requests
   input wire logic run,
   input wire logic lvl_ch2,
   input wire logic lvl_ch3,
   // towards the block
   output logic cap_pin_ch2,
   output logic cap_pin_ch3,
   output logic [capture_pkg::CNT_W-1:0] pwm_count
);
   timeunit 1ns;
   timeprecision 1ps;
   assign cap_pin_ch2 = lvl_ch2;
   assign cap_pin_ch3 = lvl_ch3;
   // down-counter frozen while run is low, so a capture sees a known value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pwm_count <= 16'hFFFF;
      else if (run)
         pwm_count <= pwm_count - 16'h0001;
   end
endmodule : capture_partner

`default_nettype wire

// ==== tb/pwm_capture_ctrl_ch2_ch3_test.sv ====
`default_nettype none

module pwm_capture_ctrl_ch2_ch3_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cap_pin_ch2;
   logic cap_pin_ch3;
   logic [15:0] pwm_count;
   logic low_density = 1'b0;
   logic flag_clear_polarity = 1'b0;
   logic irq;
   logic run = 1'b0;
   logic lvl_ch2 = 1'b0;
   logic lvl_ch3 = 1'b0;
   logic [15:0] cnt = 16'hFFFF;
   logic [15:0] f3;
   logic [31:0] rd;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #20 pclk = ~pclk;
   // =====================================================================
   // design and far side
   // =====================================================================
   pwm_capture_ctrl_ch2_ch3 pwm_capture_ctrl_ch2_ch3_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_pin_ch2(cap_pin_ch2),
      .cap_pin_ch3(cap_pin_ch3), .pwm_count(pwm_count), .low_density(low_density),
      .flag_clear_polarity(flag_clear_polarity), .irq(irq));
   capture_partner capture_partner_inst (.pclk(pclk), .presetn(presetn), .run(run),
      .lvl_ch2(lvl_ch2), .lvl_ch3(lvl_ch3), .cap_pin_ch2(cap_pin_ch2),
      .cap_pin_ch3(cap_pin_ch3), .pwm_count(pwm_count));
   // =====================================================================
   // tasks
   // =====================================================================
   task automatic report_and_stop();
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // irq follows registers that move at the edge, so look at it mid-cycle
   task automatic ichk(input logic exp);
      @(negedge pclk);
      check({31'h0, irq}, {31'h0, exp});
   endtask : ichk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rchk
   task automatic rc(input logic [31:0] exp);
      rchk(capture_pkg::CTRL_OFF, exp);
   endtask : rc
   task automatic wc(input logic [31:0] d);
      apb(1'b1, capture_pkg::CTRL_OFF, d);
      repeat (6) @(posedge pclk);
   endtask : wc
   // advance the counter three steps, then move one pin and let it settle
   task automatic pin(input logic ch3, input logic lvl);
      @(posedge pclk);
      run <= 1'b1;
      repeat (3) @(posedge pclk);
      run <= 1'b0;
      cnt = cnt - 16'h0003;
      if (ch3)
         lvl_ch3 <= lvl;
      else
         lvl_ch2 <= lvl;
      repeat (6) @(posedge pclk);
   endtask : pin
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   // =====================================================================
   // sequence
   // =====================================================================
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 8'h54; a <= 8'h84; a += 4)
         rchk(8'(a), 32'h0000_0000);
      apb(1'b1, 8'h58, 32'hFFFF_FFFF);
      pin(1'b0, 1'b1);
      rchk(capture_pkg::CH2_RISE_OFF, 32'h0000_0000);
      rc(32'h0000_0000);
      wc(32'hFF00_FF2E);
      rc(32'h0000_000E);
      pin(1'b0, 1'b0);
      rchk(capture_pkg::CH2_FALL_OFF, {16'h0000, cnt});
      rc(32'h0000_009E);
      ichk(1'b0);
      apb(1'b1, capture_pkg::IRQ_MASK_OFF, 32'h0000_0001);
      ichk(1'b1);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0001);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0000);
      wc(32'h0000_001E);
      rc(32'h0000_000E);
      pin(1'b0, 1'b1);
      rchk(capture_pkg::CH2_RISE_OFF, {16'h0000, cnt});
      rc(32'h0000_005E);
      ichk(1'b1);
      wc(32'h0000_00CE);
      rc(32'h0000_005E);
      low_density <= 1'b1;
      flag_clear_polarity <= 1'b1;
      wc(32'h0000_000E);
      rc(32'h0000_005E);
      wc(32'h0000_004E);
      rc(32'h0000_001E);
      flag_clear_polarity <= 1'b0;
      pin(1'b0, 1'b0);
      wc(32'h0000_009E);
      rc(32'h0000_008E);
      wc(32'h0000_000E);
      rc(32'h0000_000E);
      low_density <= 1'b0;
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0001);
      wc(32'h0000_0008);
      pin(1'b0, 1'b1);
      rc(32'h0000_0048);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0000);
      apb(1'b1, capture_pkg::IRQ_MASK_OFF, 32'h0000_0003);
      wc(32'h000F_0000);
      rchk(capture_pkg::CH3_RISE_OFF, {16'h0000, cnt});
      rc(32'h005F_0000);
      ichk(1'b1);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0002);
      pin(1'b1, 1'b1);
      f3 = cnt;
      rchk(capture_pkg::CH3_FALL_OFF, {16'h0000, f3});
      rc(32'h00DF_0000);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0002);
      wc(32'h0019_0000);
      rc(32'h0009_0000);
      pin(1'b1, 1'b0);
      rchk(capture_pkg::CH3_RISE_OFF, {16'h0000, cnt});
      rc(32'h0049_0000);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0000);
      wc(32'h0007_0000);
      pin(1'b1, 1'b1);
      rchk(capture_pkg::CH3_FALL_OFF, {16'h0000, f3});
      rc(32'h0007_0000);
      rchk(capture_pkg::IRQ_STATUS_OFF, 32'h0000_0000);
      report_and_stop();
   end
endmodule : pwm_capture_ctrl_ch2_ch3_test

bind pwm_capture_ctrl_ch2_ch3 capture_properties capture_properties_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cap_pin_ch2(cap_pin_ch2), .cap_pin_ch3(cap_pin_ch3), .pwm_count(pwm_count),
   .low_density(low_density), .flag_clear_polarity(flag_clear_polarity), .irq(irq));

`default_nettype wire
